/* File: core/intc_power.sv */
// interrupt prioritisation, vectoring and low-power mode control with an AXI4-Lite register port
`timescale 1ns/1ns
module intc_power
  import intc_power_pkg::*;
#(
  parameter logic [15:0] CODE_BASE = CODE_BASE_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reset sources
  input wire logic power_up_flag,
  input wire logic external_reset_flag,
  input wire logic watchdog_flag,
  input wire logic flash_key_violation_flag,
  // nonmaskable-class flags
  input wire logic nonmaskable_pin_flag,
  input wire logic oscillator_fault_flag,
  input wire logic flash_access_violation_flag,
  // maskable flags, already gated by their peripheral enables
  input wire logic watchdog_interval_flag,
  input wire logic timer_channel0_flag,
  input wire logic timer_channel1_flag,
  input wire logic timer_overflow_flag,
  input wire logic converter_done_flag,
  input wire logic serial_unit_flag,
  input wire logic serial_start_flag,
  input wire logic [7:0] port1_pin_flags,
  input wire logic [1:0] port2_pin_flags,
  // processor core
  input wire logic general_irq_enable,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic reset_vector_valid,
  input wire logic [15:0] reset_vector_word,
  input wire logic irq_ack,
  input wire logic handler_return,
  output logic irq_request,
  output logic [15:0] irq_vector_addr,
  output logic system_reset_req,
  output clock_gates_t clock_gates,
  output logic event_irq
);

  // a code base below the top of information memory would make illegal fetches look legal
  if (CODE_BASE < INFO_TOP || CODE_BASE[0] != 1'b0) begin : g_bad_code_base
    $error("code base must lie above information memory and be word aligned");
  end

  op_mode_t mode;
  op_mode_t saved_mode;
  op_mode_t next_mode;
  logic [2:0] nmi_enable;
  logic dco_used;
  logic [3:0] event_status;
  logic [3:0] event_mask;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic fetch_illegal(input logic [15:0] a);
    fetch_illegal = !((a >= RAM_BASE && a <= RAM_TOP) || (a >= INFO_BASE && a <= INFO_TOP) || a >= CODE_BASE);
  endfunction : fetch_illegal

  function automatic op_mode_t decode_mode(input logic [2:0] code);
    unique case (code)
      MODE_CODE_SLEEP0: decode_mode = sleep_mode_zero;
      MODE_CODE_SLEEP1: decode_mode = sleep_mode_one;
      MODE_CODE_SLEEP2: decode_mode = sleep_mode_two;
      MODE_CODE_SLEEP3: decode_mode = sleep_mode_three;
      MODE_CODE_SLEEP4: decode_mode = sleep_mode_four;
      default: decode_mode = active_run_mode;
    endcase
  endfunction : decode_mode

  function automatic logic [2:0] encode_mode(input op_mode_t m);
    unique case (m)
      sleep_mode_zero: encode_mode = MODE_CODE_SLEEP0;
      sleep_mode_one: encode_mode = MODE_CODE_SLEEP1;
      sleep_mode_two: encode_mode = MODE_CODE_SLEEP2;
      sleep_mode_three: encode_mode = MODE_CODE_SLEEP3;
      sleep_mode_four: encode_mode = MODE_CODE_SLEEP4;
      default: encode_mode = MODE_CODE_ACTIVE;
    endcase
  endfunction : encode_mode

  // request vector indexed by priority; flags stay in the peripherals
  wire reset_source = power_up_flag | external_reset_flag | watchdog_flag | flash_key_violation_flag;
  wire fetch_violation = fetch_valid && fetch_illegal(fetch_addr);
  wire nmi_class = (nonmaskable_pin_flag & nmi_enable[NMIEN_PIN_BIT])
    | (oscillator_fault_flag & nmi_enable[NMIEN_OSC_BIT])
    | (flash_access_violation_flag & nmi_enable[NMIEN_ACCV_BIT]);
  wire gie = general_irq_enable;
  logic [31:0] req_by_prio;
  always_comb begin
    req_by_prio = 32'h0000_0000; // priorities 15..0 and empty slots stay zero
    req_by_prio[PRIO_RESET] = reset_source | fetch_violation;
    req_by_prio[PRIO_NMI] = nmi_class; // global enable not applied
    req_by_prio[PRIO_WDT_INTERVAL] = gie & watchdog_interval_flag;
    req_by_prio[PRIO_TIMER_CH0] = gie & timer_channel0_flag;
    req_by_prio[PRIO_TIMER_SHARED] = gie & (timer_channel1_flag | timer_overflow_flag);
    req_by_prio[PRIO_CONVERTER] = gie & converter_done_flag;
    req_by_prio[PRIO_SERIAL] = gie & (serial_unit_flag | serial_start_flag);
    req_by_prio[PRIO_PORT2] = gie & (|port2_pin_flags);
    req_by_prio[PRIO_PORT1] = gie & (|port1_pin_flags);
  end

  // highest set priority wins; lower ones wait for their turn
  logic [4:0] win_prio;
  always_comb begin
    win_prio = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (req_by_prio[i]) begin
        win_prio = 5'(i);
      end
    end
  end
  wire any_req = |req_by_prio;
  wire irq_pending = |req_by_prio[31:1] && any_req && !req_by_prio[PRIO_RESET];
  wire [15:0] win_vector = VECTOR_TABLE_BASE + {10'h000, win_prio, 1'b0};
  wire reset_event = req_by_prio[PRIO_RESET];
  wire blank_vector = reset_vector_valid && reset_vector_word == BLANK_VECTOR_WORD;

  // AXI4-Lite decode
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire wr_lane0 = wr_fire && w_strb[0];
  wire wr_power = wr_lane0 && aw_addr == OFS_POWER_CTRL;
  wire wr_nmi_en = wr_lane0 && aw_addr == OFS_NMI_ENABLE;
  wire wr_status = wr_lane0 && aw_addr == OFS_EVENT_STATUS;
  wire wr_mask = wr_lane0 && aw_addr == OFS_EVENT_MASK;
  wire wr_mapped = aw_addr == OFS_POWER_CTRL || aw_addr == OFS_NMI_ENABLE
    || aw_addr == OFS_EVENT_STATUS || aw_addr == OFS_EVENT_MASK || aw_addr == OFS_VECTOR_VIEW;
  wire [2:0] req_code = w_data[PWR_MODE_LSB +: 3];
  wire sleep_write = wr_power && req_code <= MODE_CODE_SLEEP4 && mode == active_run_mode;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  logic [31:0] rd_value;
  logic rd_mapped;
  always_comb begin
    rd_mapped = 1'b1;
    unique case (s_axi_araddr)
      OFS_POWER_CTRL: rd_value = {28'h0000000, dco_used, encode_mode(mode)};
      OFS_NMI_ENABLE: rd_value = {29'h00000000, nmi_enable};
      OFS_EVENT_STATUS: rd_value = {28'h0000000, event_status};
      OFS_EVENT_MASK: rd_value = {28'h0000000, event_mask};
      OFS_VECTOR_VIEW: rd_value = {11'h000, win_prio, win_vector};
      default: begin
        rd_value = 32'h0000_0000;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // mode sequencing: blank vector wins, then reset, then wake, then return, then software request
  always_comb begin
    next_mode = mode;
    if (blank_vector) begin
      next_mode = sleep_mode_four;
    end else if (reset_event) begin
      next_mode = active_run_mode;
    end else if (mode != active_run_mode && irq_pending) begin
      next_mode = active_run_mode;
    end else if (handler_return && mode == active_run_mode) begin
      next_mode = saved_mode;
    end else if (sleep_write) begin
      next_mode = decode_mode(req_code);
    end
  end
  wire waking = mode != active_run_mode && next_mode == active_run_mode && !reset_event;

  // clock gate table per mode
  clock_gates_t next_gates;
  always_comb begin
    next_gates = '{cpu_run: 1'b1, aclk_run: 1'b1, mclk_run: 1'b1, sub_main_clock_run: 1'b1,
                   dc_gen_run: 1'b1, xtal_run: 1'b1};
    unique case (next_mode)
      active_run_mode: next_gates.dc_gen_run = 1'b1;
      sleep_mode_zero: begin
        next_gates.cpu_run = 1'b0;
        next_gates.mclk_run = 1'b0;
      end
      sleep_mode_one: begin
        next_gates.cpu_run = 1'b0;
        next_gates.mclk_run = 1'b0;
        next_gates.dc_gen_run = dco_used;
      end
      sleep_mode_two: begin
        next_gates.cpu_run = 1'b0;
        next_gates.mclk_run = 1'b0;
        next_gates.sub_main_clock_run = 1'b0;
      end
      sleep_mode_three: begin
        next_gates.cpu_run = 1'b0;
        next_gates.mclk_run = 1'b0;
        next_gates.sub_main_clock_run = 1'b0;
        next_gates.dc_gen_run = 1'b0;
      end
      sleep_mode_four: begin
        next_gates = '0;
      end
    endcase
  end

  wire [3:0] event_set = {blank_vector, nmi_class, waking, reset_event};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= active_run_mode;
      saved_mode <= active_run_mode;
      clock_gates <= '{cpu_run: 1'b1, aclk_run: 1'b1, mclk_run: 1'b1, sub_main_clock_run: 1'b1,
                       dc_gen_run: 1'b1, xtal_run: 1'b1};
    end else begin
      mode <= next_mode;
      clock_gates <= next_gates;
      // a mode entered by software while no interrupt is pending is the one a later return goes back to
      if (sleep_write && !reset_event && !irq_pending) begin
        saved_mode <= decode_mode(req_code);
      end else if (reset_event || (handler_return && mode == active_run_mode)) begin
        saved_mode <= active_run_mode;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request <= 1'b0;
      irq_vector_addr <= RESET_VECTOR_ADDR;
      system_reset_req <= 1'b0;
    end else begin
      irq_request <= irq_pending && !irq_ack;
      irq_vector_addr <= reset_event ? RESET_VECTOR_ADDR : win_vector;
      system_reset_req <= reset_event;
    end
  end

  // registers; hardware set beats a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_enable <= RST_NMI_ENABLE;
      dco_used <= RST_DCO_USED;
      event_status <= 4'h0;
      event_mask <= RST_EVENT_MASK;
      event_irq <= 1'b0;
    end else begin
      if (wr_nmi_en) begin
        nmi_enable <= w_data[2:0];
      end
      if (wr_power) begin
        dco_used <= w_data[PWR_DCO_USED_BIT];
      end
      if (wr_mask) begin
        event_mask <= w_data[3:0];
      end
      event_status <= (event_status & ~(wr_status ? w_data[3:0] : 4'h0)) | event_set;
      event_irq <= |(event_status & event_mask);
    end
  end

  // AXI4-Lite handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_held && !w_take && !s_axi_bvalid;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !ar_take && !s_axi_arready;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  sequence s_sleeping;
    mode != active_run_mode;
  endsequence
  sequence s_woken;
    mode == active_run_mode ##0 clock_gates.cpu_run;
  endsequence

  a_reset_vector_out: assert property (@(posedge aclk) disable iff (!aresetn)
    reset_event |=> system_reset_req && irq_vector_addr == 16'hFFFE)
    else $error("reset source did not select FFFE");
  a_fetch_violation_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (fetch_valid && fetch_addr <= PERIPH_REGION_TOP) |=> system_reset_req)
    else $error("fetch from peripheral region gave no reset");
  a_blank_vector_sleep: assert property (@(posedge aclk) disable iff (!aresetn)
    blank_vector |=> mode == sleep_mode_four && clock_gates == '0)
    else $error("blank reset vector did not stop every clock");
  a_nmi_ignores_gie: assert property (@(posedge aclk) disable iff (!aresetn)
    (!general_irq_enable && oscillator_fault_flag && nmi_enable[NMIEN_OSC_BIT] && !reset_event)
      |=> irq_vector_addr == 16'hFFFC)
    else $error("nonmaskable request blocked by global enable");
  a_nmi_enable_gates: assert property (@(posedge aclk) disable iff (!aresetn)
    (nmi_enable == 3'h0 && !gie && !reset_event) |=> !irq_request)
    else $error("disabled nonmaskable source raised a request");
  a_priority_order: assert property (@(posedge aclk) disable iff (!aresetn)
    (gie && timer_channel0_flag && |port1_pin_flags && !nmi_class && !reset_event && !watchdog_interval_flag)
      |=> irq_vector_addr == 16'hFFF2)
    else $error("lower priority vector served first");
  a_port_vectors: assert property (@(posedge aclk) disable iff (!aresetn)
    (req_by_prio[31:19] == 13'h0000 && gie && |port1_pin_flags) |=> irq_vector_addr == 16'hFFE4)
    else $error("port 1 vector wrong");
  a_low_slots_empty: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_request |-> irq_vector_addr >= 16'hFFE0)
    else $error("request served from an unattached low slot");
  a_wake_on_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_sleeping ##0 irq_pending ##0 !reset_event ##0 !blank_vector) |=> s_woken ##0 event_status[EV_WAKE_BIT])
    else $error("pending interrupt did not wake the device");
  a_return_restores: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == active_run_mode && handler_return && !irq_pending && !reset_event && !blank_vector)
      |=> mode == $past(saved_mode))
    else $error("return did not restore the saved mode");
  a_sleep_gates: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == sleep_mode_two |-> !clock_gates.mclk_run && !clock_gates.sub_main_clock_run
      && clock_gates.dc_gen_run && clock_gates.aclk_run && !clock_gates.cpu_run)
    else $error("sleep mode two gates wrong");
  a_mode_three_gates: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == sleep_mode_three && next_mode == sleep_mode_three) |=> clock_gates.aclk_run
      && !clock_gates.dc_gen_run && !clock_gates.sub_main_clock_run && !clock_gates.cpu_run)
    else $error("sleep mode three gates wrong");

endmodule : intc_power

/* File: pkg/intc_power_pkg.sv */
// constants, types and register map of the interrupt vector and power mode controller
package intc_power_pkg;
  // vector table and priorities
  localparam logic [15:0] VECTOR_TABLE_BASE = 16'hFFC0;
  localparam logic [15:0] VECTOR_TABLE_TOP = 16'hFFFF;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
  localparam logic [15:0] BLANK_VECTOR_WORD = 16'hFFFF;
  localparam logic [4:0] PRIO_RESET = 5'h1F;
  localparam logic [4:0] PRIO_NMI = 5'h1E;
  localparam logic [4:0] PRIO_WDT_INTERVAL = 5'h1A;
  localparam logic [4:0] PRIO_TIMER_CH0 = 5'h19;
  localparam logic [4:0] PRIO_TIMER_SHARED = 5'h18;
  localparam logic [4:0] PRIO_CONVERTER = 5'h15;
  localparam logic [4:0] PRIO_SERIAL = 5'h14;
  localparam logic [4:0] PRIO_PORT2 = 5'h13;
  localparam logic [4:0] PRIO_PORT1 = 5'h12;
  localparam logic [4:0] PRIO_LOWEST_ATTACHED = 5'h10;
  // fetch address map
  localparam logic [15:0] PERIPH_REGION_TOP = 16'h01FF;
  localparam logic [15:0] RAM_BASE = 16'h0200;
  localparam logic [15:0] RAM_TOP = 16'h027F;
  localparam logic [15:0] INFO_BASE = 16'h1000;
  localparam logic [15:0] INFO_TOP = 16'h10FF;
  localparam logic [15:0] CODE_BASE_DEFAULT = 16'hF800;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_POWER_CTRL = 8'h00;
  localparam logic [7:0] OFS_NMI_ENABLE = 8'h04;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h08;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h0C;
  localparam logic [7:0] OFS_VECTOR_VIEW = 8'h10;
  // fields
  localparam int PWR_MODE_LSB = 0;
  localparam int PWR_DCO_USED_BIT = 3;
  localparam int NMIEN_PIN_BIT = 0;
  localparam int NMIEN_OSC_BIT = 1;
  localparam int NMIEN_ACCV_BIT = 2;
  localparam int EV_RESET_BIT = 0;
  localparam int EV_WAKE_BIT = 1;
  localparam int EV_NMI_BIT = 2;
  localparam int EV_BLANK_BIT = 3;
  localparam int VIEW_PRIO_LSB = 16;
  // reset values
  localparam logic [2:0] RST_NMI_ENABLE = 3'h0;
  localparam logic [3:0] RST_EVENT_MASK = 4'h0;
  localparam logic RST_DCO_USED = 1'b1;
  // software mode codes and AXI4-Lite response codes
  localparam logic [2:0] MODE_CODE_ACTIVE = 3'h0;
  localparam logic [2:0] MODE_CODE_SLEEP0 = 3'h1;
  localparam logic [2:0] MODE_CODE_SLEEP1 = 3'h2;
  localparam logic [2:0] MODE_CODE_SLEEP2 = 3'h3;
  localparam logic [2:0] MODE_CODE_SLEEP3 = 3'h4;
  localparam logic [2:0] MODE_CODE_SLEEP4 = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    active_run_mode = 6'h01,
    sleep_mode_zero = 6'h02,
    sleep_mode_one = 6'h04,
    sleep_mode_two = 6'h08,
    sleep_mode_three = 6'h10,
    sleep_mode_four = 6'h20
  } op_mode_t;

  typedef struct packed {
    logic cpu_run;
    logic aclk_run;
    logic mclk_run;
    logic sub_main_clock_run;
    logic dc_gen_run;
    logic xtal_run;
  } clock_gates_t;
endpackage : intc_power_pkg

/* File: testbench/periph_model.sv */
// peripheral flag holders and core acknowledge model
`timescale 1ns/1ns
module periph_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [16:0] raise,
  input wire logic [2:0] dly,
  input wire logic irq_request,
  input wire logic [15:0] irq_vector_addr,
  output logic [16:0] flags,
  output logic irq_ack
);
  logic [2:0] w;
  logic hold;
  logic [16:0] served;
  wire logic [15:0] v = irq_vector_addr;
  assign served = v == 16'hFFF4 ? 17'h00001 : v == 16'hFFF2 ? 17'h00002 : v == 16'hFFF0 ? 17'h0000C :
    v == 16'hFFEA ? 17'h00010 : v == 16'hFFE8 ? 17'h00060 : v == 16'hFFE6 ? 17'h18000 :
    v == 16'hFFE4 ? 17'h07F80 : 17'h00000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
      w <= '0;
      hold <= 1'b0;
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      // a flag lives here until its handler is acknowledged
      flags <= (flags | raise) & ~(irq_ack ? served : 17'h00000);
      // one acknowledge per request; slow answers wait dly cycles
      if (!irq_request) begin
        hold <= 1'b0;
      end else if (!hold) begin
        if (w == dly) begin
          irq_ack <= 1'b1;
          hold <= 1'b1;
          w <= '0;
        end else begin
          w <= w + 3'h1;
        end
      end
    end
  end
endmodule : periph_model

/* File: testbench/tb_interrupt_vector_and_power_mode_control.sv */
// self-checking bench for the interrupt and power mode controller
`timescale 1ns/1ns
module tb_interrupt_vector_and_power_mode_control;
  import intc_power_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, gie = 0, fetch_valid = 0, rv_valid = 0, handler_return = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat, s = 32'hB0D4EB3A;
  logic [15:0] fetch_addr = 0, rv_word = 0, irq_vector_addr;
  logic [16:0] raise = 0, flags;
  logic [3:0] rsrc = 0;
  logic [2:0] nmi_f = 0, dly = 3'h1, m;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq_request, system_reset_req, event_irq, irq_ack;
  clock_gates_t clock_gates;
  int n_errors = 0, tests_run = 0, i, k;
  logic [15:0] fa [4] = '{16'h0100, 16'h0200, 16'h0300, 16'hF800};
  logic [7:0] ra [4] = '{OFS_POWER_CTRL, OFS_NMI_ENABLE, OFS_EVENT_MASK, 8'h14};
  always #50 aclk = ~aclk;
  intc_power intc_power_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .power_up_flag(rsrc[0]), .external_reset_flag(rsrc[1]), .watchdog_flag(rsrc[2]),
    .flash_key_violation_flag(rsrc[3]), .nonmaskable_pin_flag(nmi_f[0]), .oscillator_fault_flag(nmi_f[1]),
    .flash_access_violation_flag(nmi_f[2]), .watchdog_interval_flag(flags[0]), .timer_channel0_flag(flags[1]),
    .timer_channel1_flag(flags[2]), .timer_overflow_flag(flags[3]), .converter_done_flag(flags[4]),
    .serial_unit_flag(flags[5]), .serial_start_flag(flags[6]), .port1_pin_flags(flags[14:7]),
    .port2_pin_flags(flags[16:15]), .general_irq_enable(gie), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .reset_vector_valid(rv_valid), .reset_vector_word(rv_word), .irq_ack(irq_ack),
    .handler_return(handler_return), .irq_request(irq_request), .irq_vector_addr(irq_vector_addr),
    .system_reset_req(system_reset_req), .clock_gates(clock_gates), .event_irq(event_irq));
  periph_model periph_model_i (.aclk(aclk), .aresetn(aresetn), .raise(raise), .dly(dly),
    .irq_request(irq_request), .irq_vector_addr(irq_vector_addr), .flags(flags), .irq_ack(irq_ack));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [15:0] exp_vec(input logic [16:0] p);
    logic [4:0] q;
    q = p[0] ? 5'h1A : p[1] ? 5'h19 : |p[3:2] ? 5'h18 : p[4] ? 5'h15 : |p[6:5] ? 5'h14 : |p[16:15] ? 5'h13 : 5'h12;
    return VECTOR_TABLE_BASE + {10'h000, q, 1'b0};
  endfunction : exp_vec
  function automatic logic [5:0] exp_gates(input logic [2:0] c, input logic d);
    case (c)
      3'h1: return 6'h17;
      3'h2: return d ? 6'h17 : 6'h15;
      3'h3: return 6'h13;
      3'h4: return 6'h11;
      3'h5: return 6'h00;
      default: return 6'h3F;
    endcase
  endfunction : exp_gates
  task automatic close_out();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tmo();
    n_errors++;
    $display("BAD %0t wait ran out", $time);
    close_out();
  endtask : tmo
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic rst();
    aresetn <= 1'b0;
    cyc(10);
    aresetn <= 1'b1;
    cyc(1);
  endtask : rst
  // ready is read at the falling edge, so the release lands on the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      rrsp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end while (!tb && n < 40);
    s_axi_bready <= 1'b0;
    if (!tb) tmo();
    // one idle edge keeps a following call from reassigning bready in this step
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end while (!tr && n < 40);
    s_axi_rready <= 1'b0;
    if (!tr) tmo();
    @(posedge aclk);
  endtask : rd
  task automatic wait_ack();
    int n;
    for (n = 0; n < 60 && irq_ack !== 1'b1; n++) @(negedge aclk);
    if (irq_ack !== 1'b1) tmo();
  endtask : wait_ack
  initial begin
    rst();
    for (i = 0; i < 4; i++) begin
      rd(ra[i]);
      chk(rdat, i == 0 ? {28'h0, RST_DCO_USED, MODE_CODE_ACTIVE} : 32'h0);
      chk(rrsp, i == 3 ? RESP_SLVERR : RESP_OKAY);
    end
    for (i = 0; i < 4; i++) begin
      rst();
      rsrc <= 4'h1 << i;
      cyc(2);
      @(negedge aclk);
      chk(system_reset_req, 1);
      chk(irq_vector_addr, RESET_VECTOR_ADDR);
      @(posedge aclk);
      rsrc <= 4'h0;
      rst();
      fetch_valid <= 1'b1;
      fetch_addr <= fa[i];
      cyc(2);
      @(negedge aclk);
      chk(system_reset_req, !i[0]);
      @(posedge aclk);
      fetch_valid <= 1'b0;
    end
    for (i = 0; i < 2; i++) begin
      rst();
      rv_word <= i == 0 ? BLANK_VECTOR_WORD : 16'hF800;
      rv_valid <= 1'b1;
      cyc(1);
      rv_valid <= 1'b0;
      cyc(1);
      @(negedge aclk);
      chk(clock_gates, i == 0 ? 6'h00 : 6'h3F);
      @(posedge aclk);
    end
    rst();
    for (i = 0; i < 3; i++) begin
      wr(OFS_NMI_ENABLE, 32'h7 ^ (32'h1 << i));
      chk(rrsp, RESP_OKAY);
      nmi_f <= 3'h1 << i;
      cyc(3);
      @(negedge aclk);
      chk(irq_request, 0);
      @(posedge aclk);
      wr(OFS_NMI_ENABLE, 32'h1 << i);
      wait_ack();
      chk(irq_vector_addr, 16'hFFFC);
      @(posedge aclk);
      nmi_f <= 3'h0;
      cyc(3);
    end
    gie <= 1'b1;
    for (i = 0; i < 8; i++) begin
      s = lfsr(s);
      dly <= s[20] ? 3'h5 : 3'h1;
      raise <= s[16:0] | 17'h00001 << s[28:25];
      cyc(1);
      raise <= '0;
      @(negedge aclk);
      for (k = 0; flags !== 17'h0 && k < 20; k++) begin
        wait_ack();
        chk(irq_vector_addr, exp_vec(flags));
        @(negedge aclk);
      end
      if (flags !== 17'h0) tmo();
      @(posedge aclk);
    end
    for (m = 3'h1; m <= 3'h5; m++) begin
      rst();
      s = lfsr(s);
      wr(OFS_POWER_CTRL, {28'h0, s[3], m});
      cyc(2);
      @(negedge aclk);
      chk(clock_gates, exp_gates(m, s[3]));
      @(posedge aclk);
      raise <= 17'h00080;
      cyc(1);
      raise <= '0;
      wait_ack();
      chk(clock_gates, 6'h3F);
      @(posedge aclk);
      cyc(2);
      handler_return <= 1'b1;
      cyc(1);
      handler_return <= 1'b0;
      cyc(2);
      @(negedge aclk);
      chk(clock_gates, exp_gates(m, s[3]));
      @(posedge aclk);
    end
    rd(OFS_EVENT_STATUS);
    chk(rdat[EV_WAKE_BIT], 1);
    wr(OFS_EVENT_MASK, 32'h2);
    cyc(1);
    @(negedge aclk);
    chk(event_irq, 1);
    @(posedge aclk);
    wr(OFS_EVENT_STATUS, 32'h2);
    cyc(1);
    @(negedge aclk);
    chk(event_irq, 0);
    close_out();
  end
endmodule : tb_interrupt_vector_and_power_mode_control
